//--- src/spimsc_cfg.svh
`ifndef SPIMSC_CFG_SVH
`define SPIMSC_CFG_SVH
// ==========================================
// Register byte offsets
`define SPIMSC_OFF_CTRL  6'h00
`define SPIMSC_OFF_DIV   6'h04
`define SPIMSC_OFF_SEL   6'h08
`define SPIMSC_OFF_RX0   6'h10
`define SPIMSC_OFF_RX1   6'h14
`define SPIMSC_OFF_TX0   6'h20
`define SPIMSC_OFF_TX1   6'h24
`define SPIMSC_OFF_PAT   6'h34
`define SPIMSC_OFF_CTRL2 6'h3C
// ==========================================
// Control field positions
`define SPIMSC_B_GO      0
`define SPIMSC_B_INFALL  1
`define SPIMSC_B_OUTFALL 2
`define SPIMSC_B_LEN_LO  3
`define SPIMSC_B_LEN_HI  7
`define SPIMSC_B_NUM_LO  8
`define SPIMSC_B_NUM_HI  9
`define SPIMSC_B_LSB     10
`define SPIMSC_B_CPOL    11
`define SPIMSC_B_SP_LO   12
`define SPIMSC_B_SP_HI   15
`define SPIMSC_B_IFLAG   16
`define SPIMSC_B_IE      17
`define SPIMSC_B_SLAVE   18
`define SPIMSC_B_VCE     23
// Select field positions, then the second control register bit
`define SPIMSC_B_SEL_LO  0
`define SPIMSC_B_SEL_HI  1
`define SPIMSC_B_SELPOL  2
`define SPIMSC_B_AUTO    3
`define SPIMSC_B_LEVEL   4
`define SPIMSC_B_LDONE   5
`define SPIMSC_B_DIVONE  0
// ==========================================
// Reset values, burst word-count code and timing
`define SPIMSC_OUTFALL_RST 1'b1
`define SPIMSC_PAT_RST     32'h007F_FF87
`define SPIMSC_NUM_BURST   2'h1
`define SPIMSC_SUSP_BASE   24'h000002
// Divide-by-one suspend, 3.5 clocks kept doubled
`define SPIMSC_D1_SUSP_X2  24'h000007
`endif

//--- src/spimsc_pkg.sv
package spimsc_pkg;
  typedef enum logic [1:0] {
    SPIMSC_IDLE,
    SPIMSC_XFER,
    SPIMSC_SUSP,
    SPIMSC_SLV
  } spimsc_state_e_t;

  typedef struct packed {
    spimsc_state_e_t st;
    logic            go;
    logic            infall;
    logic            outfall;
    logic            lsb;
    logic            cpol;
    logic            iflag;
    logic            ie;
    logic            slave;
    logic            vce;
    logic            div_one;
    logic [4:0]      blen;
    logic [1:0]      num;
    logic [3:0]      sp;
    logic [15:0]     div1;
    logic [15:0]     div2;
    logic [31:0]     pat;
    logic [1:0]      sel;
    logic            aut;
    logic            pol;
    logic            lvl;
    logic            ldone;
    logic [31:0]     tx0;
    logic [31:0]     tx1;
    logic [31:0]     rx0;
    logic [31:0]     rx1;
    logic [31:0]     sh;
    logic [5:0]      cnt;
    logic            wd;
    logic [23:0]     hc;
    logic [4:0]      pi;
    logic            sclk;
    logic            sprev;
    logic            ssprev;
    logic            trig;
    logic            dout;
    logic            mosi_oe_n;
    logic            miso_oe_n;
    logic            irq;
    logic [1:0]      ss;
    logic [1:0]      ss_oe_n;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
  } spimsc_regs_t;
endpackage

//--- src/spimsc_top.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ns
`include "spimsc_cfg.svh"
// Overview of operation
// - Divide-by-one suspend lasts 2*field+3.5 system clocks; the code rounds 3.5 up to 4 and loads 2*field+4.
// - Clock polarity bit sets serial clock idle level.
// - Low-bit-first sends bit 0 first and stores first bit there.
// - Word count 00 runs one word, 01 runs two words.
// - Bit length field gives 1 to 31 bits, code 0 means 32.
// - Output edge bit picks falling or rising clock edge for data out.
// - Input edge bit picks falling or rising clock edge for sampling.
// - Master: writing go starts a transfer.
// - Slave: writing go arms for an externally clocked transfer.
// - Go reads one while busy, self-clears; writing zero stops it.
// - Serial clock is system clock over 2*(primary ratio+1).
// - Second ratio uses same formula, only with variable clock on.
// - Level-trigger done flag shows word count and length were met.
// - Select trigger bit chooses level or edge sensitive select.
// - Automatic select drives lines during transfer, else bits direct.
// - Select polarity bit chooses active high or active low.
// - Manual select bits drive lines active or inactive.
// - Automatic mode: zero bit keeps line idle, one bit during transfer.
// - In slave mode select line 0 is an input.
// - Receive words hold last transfer, configured bits valid.
// - Normal suspend is field+2 serial clocks plus one system clock.
// - Done flag set on completion, write-one clears, gated by enable.
// - Variable clock: pattern bit zero uses primary, one uses second.
module spimsc_top (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe_n,
  input  wire logic [1:0]  slave_select_lines_i,
  output logic      [1:0]  slave_select_lines_o,
  output logic      [1:0]  slave_select_lines_oe_n,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe_n,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe_n,
  output logic             irq
);
  spimsc_pkg::spimsc_regs_t r;
  spimsc_pkg::spimsc_regs_t n;

  logic [5:0]  nbits;
  logic [23:0] half;
  logic [31:0] txw;
  logic        din;
  logic        tick;
  logic        rxe;
  logic        txe;
  logic        wend;
  logic        ssa;
  logic        en;
  logic        rise;
  logic        fall;
  logic        wr;
  logic        busy;

  // ==========================================
  // Bit position of the n-th bit on the line
  function automatic logic [4:0] bit_idx(
    input logic [5:0] c,
    input logic [5:0] nb,
    input logic       lsbf
  );
    logic [5:0] t;
    t = nb - 6'h01 - c;
    bit_idx = lsbf ? c[4:0] : t[4:0];
  endfunction

  // ==========================================
  // Next state
  always_comb begin
    n = r;
    nbits = (r.blen == 5'h00) ? 6'h20 : {1'b0, r.blen};
    if (r.div_one) begin
      half = 24'h000000;
    end else if (r.vce && r.pat[r.pi]) begin
      half = {8'h00, r.div2};
    end else begin
      half = {8'h00, r.div1};
    end
    txw  = r.wd ? r.tx1 : r.tx0;
    din  = r.slave ? mosi_i : miso_i;
    busy = r.st != spimsc_pkg::SPIMSC_IDLE;
    wr   = psel && penable && r.pready && pwrite;

    // ------------------------------------------
    // APB: no wait states, answer from flops
    n.pready  = psel && !penable;
    n.pslverr = 1'b0;
    n.prdata  = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      case (paddr[5:0])
        `SPIMSC_OFF_CTRL: begin
          n.prdata = {8'h00, r.vce, 4'h0, r.slave, r.ie, r.iflag,
                      r.sp, r.cpol, r.lsb, r.num, r.blen,
                      r.outfall, r.infall, r.go};
        end
        `SPIMSC_OFF_DIV:   n.prdata = {r.div2, r.div1};
        `SPIMSC_OFF_SEL: begin
          n.prdata = {26'h0, r.ldone, r.lvl, r.aut, r.pol, r.sel};
        end
        `SPIMSC_OFF_RX0:   n.prdata = r.rx0;
        `SPIMSC_OFF_RX1:   n.prdata = r.rx1;
        `SPIMSC_OFF_TX0:   n.prdata = 32'h0000_0000;
        `SPIMSC_OFF_TX1:   n.prdata = 32'h0000_0000;
        `SPIMSC_OFF_PAT:   n.prdata = r.pat;
        `SPIMSC_OFF_CTRL2: n.prdata = {31'h0, r.div_one};
        default:           n.pslverr = 1'b1;
      endcase
    end else if (psel && !penable) begin
      case (paddr[5:0])
        `SPIMSC_OFF_CTRL, `SPIMSC_OFF_DIV, `SPIMSC_OFF_SEL,
        `SPIMSC_OFF_TX0, `SPIMSC_OFF_TX1, `SPIMSC_OFF_PAT,
        `SPIMSC_OFF_CTRL2: n.pslverr = 1'b0;
        default:           n.pslverr = 1'b1;
      endcase
    end

    if (wr) begin
      case (paddr[5:0])
        `SPIMSC_OFF_CTRL: begin
          n.infall  = pwdata[`SPIMSC_B_INFALL];
          n.outfall = pwdata[`SPIMSC_B_OUTFALL];
          n.blen    = pwdata[`SPIMSC_B_LEN_HI:`SPIMSC_B_LEN_LO];
          n.num     = pwdata[`SPIMSC_B_NUM_HI:`SPIMSC_B_NUM_LO];
          n.lsb     = pwdata[`SPIMSC_B_LSB];
          n.cpol    = pwdata[`SPIMSC_B_CPOL];
          n.sp      = pwdata[`SPIMSC_B_SP_HI:`SPIMSC_B_SP_LO];
          n.ie      = pwdata[`SPIMSC_B_IE];
          n.slave   = pwdata[`SPIMSC_B_SLAVE];
          n.vce     = pwdata[`SPIMSC_B_VCE];
          n.go      = pwdata[`SPIMSC_B_GO];
          if (pwdata[`SPIMSC_B_IFLAG]) begin
            n.iflag = 1'b0;
          end
        end
        `SPIMSC_OFF_DIV: begin
          n.div1 = pwdata[15:0];
          n.div2 = pwdata[31:16];
        end
        `SPIMSC_OFF_SEL: begin
          n.sel = pwdata[`SPIMSC_B_SEL_HI:`SPIMSC_B_SEL_LO];
          n.pol = pwdata[`SPIMSC_B_SELPOL];
          n.aut = pwdata[`SPIMSC_B_AUTO];
          n.lvl = pwdata[`SPIMSC_B_LEVEL];
        end
        `SPIMSC_OFF_TX0: begin
          if (!busy && !r.go) begin
            n.tx0 = pwdata;
          end
        end
        `SPIMSC_OFF_TX1: begin
          if (!busy && !r.go) begin
            n.tx1 = pwdata;
          end
        end
        `SPIMSC_OFF_PAT:   n.pat = pwdata;
        `SPIMSC_OFF_CTRL2: n.div_one = pwdata[`SPIMSC_B_DIVONE];
        default: begin
        end
      endcase
    end

    // ------------------------------------------
    // Edge sources: own divider or sampled pin
    n.sprev  = serial_clock_pin_i;
    n.ssprev = slave_select_lines_i[0];
    rise = serial_clock_pin_i && !r.sprev;
    fall = !serial_clock_pin_i && r.sprev;
    ssa  = slave_select_lines_i[0] == r.pol;
    en   = r.lvl ? ssa
                 : (r.trig || (ssa && (r.ssprev != r.pol)));
    tick = (r.st == spimsc_pkg::SPIMSC_XFER) && (r.hc == half);
    rxe  = 1'b0;
    txe  = 1'b0;
    wend = 1'b0;
    if (tick && !((r.cnt == nbits) && (r.sclk == r.cpol))) begin
      rxe = (!r.sclk) != r.infall;
      txe = (!r.sclk) != r.outfall;
    end
    if (r.st == spimsc_pkg::SPIMSC_SLV && en && r.cnt != nbits) begin
      rxe = r.infall ? fall : rise;
      txe = r.outfall ? fall : rise;
    end

    if (rxe) begin
      n.sh[bit_idx(r.cnt, nbits, r.lsb)] = din;
      n.cnt = r.cnt + 6'h01;
    end
    if (txe) begin
      n.dout = txw[bit_idx(n.cnt, nbits, r.lsb)];
    end

    // ------------------------------------------
    // Transfer sequencing
    case (r.st)
      spimsc_pkg::SPIMSC_IDLE: begin
        n.sclk = r.cpol;
        n.trig = 1'b0;
        if (r.go) begin
          n.cnt   = 6'h00;
          n.wd    = 1'b0;
          n.hc    = 24'h000000;
          n.pi    = 5'h00;
          n.sh    = 32'h0000_0000;
          n.ldone = 1'b0;
          n.dout  = r.tx0[bit_idx(6'h00, nbits, r.lsb)];
          n.st    = r.slave ? spimsc_pkg::SPIMSC_SLV
                            : spimsc_pkg::SPIMSC_XFER;
        end
      end
      spimsc_pkg::SPIMSC_XFER: begin
        if (tick) begin
          n.hc = 24'h000000;
          if ((r.cnt == nbits) && (r.sclk == r.cpol)) begin
            wend = 1'b1;
          end else begin
            n.sclk = !r.sclk;
            n.pi   = r.pi + 5'h01;
          end
        end else begin
          n.hc = r.hc + 24'h000001;
        end
      end
      spimsc_pkg::SPIMSC_SUSP: begin
        if (r.hc == 24'h000000) begin
          n.st = spimsc_pkg::SPIMSC_XFER;
        end else begin
          n.hc = r.hc - 24'h000001;
        end
      end
      spimsc_pkg::SPIMSC_SLV: begin
        if (en && !r.lvl) begin
          n.trig = 1'b1;
        end
        if (rxe && n.cnt == nbits) begin
          wend = 1'b1;
        end
      end
      default: n.st = spimsc_pkg::SPIMSC_IDLE;
    endcase

    if (wend) begin
      if (r.wd) begin
        n.rx1 = n.sh;
      end else begin
        n.rx0 = n.sh;
      end
      if (r.num == `SPIMSC_NUM_BURST && !r.wd) begin
        n.wd   = 1'b1;
        n.cnt  = 6'h00;
        n.sh   = 32'h0000_0000;
        n.dout = r.tx1[bit_idx(6'h00, nbits, r.lsb)];
        if (!r.slave) begin
          n.st = spimsc_pkg::SPIMSC_SUSP;
          if (r.div_one) begin
            // 3.5 rounded up to whole clocks
            n.hc = ({20'h0, r.sp} << 1)
                 + ((`SPIMSC_D1_SUSP_X2 + 24'h000001) >> 1);
          end else begin
            // the cycle spent at count zero supplies the extra clock
            n.hc = 24'(({20'h0, r.sp} + `SPIMSC_SUSP_BASE)
                 * ({8'h00, r.div1} + 24'h000001) * 24'h000002);
          end
        end
      end else begin
        n.go    = 1'b0;
        n.iflag = 1'b1;
        n.st    = spimsc_pkg::SPIMSC_IDLE;
        n.ldone = r.slave && r.lvl;
      end
    end

    // Stop on go cleared mid-transfer
    if (!r.go && busy) begin
      n.st = spimsc_pkg::SPIMSC_IDLE;
    end

    // ------------------------------------------
    // Pin drive
    n.irq       = n.iflag && n.ie;
    n.mosi_oe_n = n.slave;
    n.miso_oe_n = !(n.slave && n.st == spimsc_pkg::SPIMSC_SLV && en);
    for (int i = 0; i < 2; i++) begin
      if (n.aut ? (n.sel[i] && n.st != spimsc_pkg::SPIMSC_IDLE)
                : n.sel[i]) begin
        n.ss[i] = n.pol;
      end else begin
        n.ss[i] = !n.pol;
      end
      n.ss_oe_n[i] = (i == 0) && n.slave;
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      r         <= '0;
      r.outfall <= `SPIMSC_OUTFALL_RST;
      r.pat     <= `SPIMSC_PAT_RST;
      r.ss      <= 2'h3;
    end else begin
      r <= n;
    end
  end

  assign prdata                  = r.prdata;
  assign pready                  = r.pready;
  assign pslverr                 = r.pslverr;
  assign serial_clock_pin_o      = r.sclk;
  assign serial_clock_pin_oe_n   = r.slave;
  assign slave_select_lines_o    = r.ss;
  assign slave_select_lines_oe_n = r.ss_oe_n;
  assign mosi_o                  = r.dout;
  assign mosi_oe_n               = r.mosi_oe_n;
  assign miso_o                  = r.dout;
  assign miso_oe_n               = r.miso_oe_n;
  assign irq                     = r.irq;
endmodule

//--- verification/spimsc_props.sv
`timescale 1ns/1ns
module spimsc_props (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        serial_clock_pin_o,
  input wire logic        serial_clock_pin_oe_n,
  input wire logic [1:0]  slave_select_lines_o,
  input wire logic [1:0]  slave_select_lines_oe_n,
  input wire logic        irq
);
  // ====
  // Shadow of written settings, quiet count and serial clock monitors
  logic [31:0] ctrl;
  logic [15:0] div;
  logic [4:0]  select_line_bits;
  logic [1:0]  q;
  logic [16:0] hp;
  logic [6:0]  eg;
  logic [6:0]  len;
  logic        sq, run, wr, tog, go_wr;
  assign wr    = psel && penable && pready && pwrite;
  assign go_wr = wr && paddr[5:0] == 6'h00 && pwdata[0] && !pwdata[18];
  assign tog   = serial_clock_pin_o != sq;
  assign len   = ctrl[7:3] == 5'h00 ? 7'h20 : {2'h0, ctrl[7:3]};
  // Quiet count q lets registered outputs settle after a write
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= 32'h0000_0004;
      div  <= 16'h0000;
      select_line_bits  <= 5'h00;
      q    <= 2'h0;
      hp   <= 17'h0_0000;
      eg   <= 7'h00;
      sq   <= 1'h0;
      run  <= 1'h0;
    end else begin
      if (wr && paddr[5:0] == 6'h00) ctrl <= pwdata;
      if (wr && paddr[5:0] == 6'h04) div <= pwdata[15:0];
      if (wr && paddr[5:0] == 6'h08) select_line_bits <= pwdata[4:0];
      q   <= wr ? 2'h0 : (q == 2'h3 ? q : q + 2'h1);
      hp  <= tog ? 17'h0_0001 : hp + 17'h0_0001;
      eg  <= slave_select_lines_o[0] ? 7'h00
           : eg + {6'h00, tog && serial_clock_pin_o};
      sq  <= serial_clock_pin_o;
      run <= slave_select_lines_o[0] ? 1'h0 : (tog ? 1'h1 : run);
    end
  end
  // ====
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  pready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready is not a one-cycle access answer");
  idle_level_a: assert property (
    q == 2'h3 && slave_select_lines_o == 2'h3 && !ctrl[18]
    |-> serial_clock_pin_o == ctrl[11]) else $error("clock idle level");
  go_start_a: assert property (
    go_wr && select_line_bits[3] && !select_line_bits[2] && select_line_bits[0]
    |-> ##[1:3] !slave_select_lines_o[0]) else $error("no start");
  manual_sel_a: assert property (
    q == 2'h3 && !select_line_bits[3] && !ctrl[18] |-> slave_select_lines_o
    == (select_line_bits[2] ? select_line_bits[1:0] : ~select_line_bits[1:0])) else $error("manual select");
  irq_gate_a: assert property (
    !ctrl[17] && !$past(ctrl[17]) |-> !irq) else $error("irq ungated");
  half_period_a: assert property (
    tog && run && ctrl[0] && !slave_select_lines_o[0]
    && ctrl[9:8] == 2'h0 && !ctrl[18] |-> hp == {1'h0, div} + 17'h0_0001)
    else $error("serial clock half period");
  bit_count_a: assert property (
    $rose(slave_select_lines_o[0]) && select_line_bits[3] && !select_line_bits[2] && !ctrl[18]
    |-> eg == (ctrl[9:8] == 2'h1 ? {len[5:0], 1'h0} : len))
    else $error("clock count per transfer");
  slave_in_a: assert property (
    ctrl[18] && q == 2'h3
    |-> slave_select_lines_oe_n[0] && serial_clock_pin_oe_n)
    else $error("slave mode drives select or clock");
  cover property (go_wr);
  cover property ($rose(irq));
  cover property (tog && run);
endmodule
bind spimsc_top spimsc_props spimsc_props_inst (.*);

//--- verification/spimsc_partner.sv
`timescale 1ns/1ns
module spimsc_partner (
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  input  wire logic [31:0] tx,
  output logic             miso,
  output logic [31:0]      cap
);
  // ====
  // Serial slave, top bit of tx goes out first
  logic [31:0] sh;
  logic        seen;
  logic        hold_n;
  initial begin
    sh = 32'h0;
    cap = 32'h0;
    seen = 1'h0;
    hold_n = 1'h0;
  end
  always @(negedge sel_n) begin
    sh = tx;
    seen = 1'h0;
    cap = 32'h0;
  end
  // Released line shows the inverse, never a stale valid bit
  always @(posedge sel_n) hold_n = ~sh[31];
  always @(posedge sclk) begin
    if (!sel_n) cap = {cap[30:0], mosi};
    if (!sel_n) seen = 1'h1;
  end
  // A leading falling edge (idle high) must not drop bit one
  always @(negedge sclk) begin
    if (!sel_n && seen) sh = {sh[30:0], 1'h0};
  end
  assign miso = sel_n ? hold_n : sh[31];
endmodule

//--- verification/spimsc_top_tb.sv
`timescale 1ns/1ns
module spimsc_top_tb;
  logic        mclk, sys_rst, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata, ptx, cap, rd_v;
  logic        pready, pslverr, sclk, mosi, miso, irq, lerr;
  logic [1:0]  ss, ss_oe_n, s_sel;
  logic        s_clk, s_mosi, s_miso;
  logic [15:0] s_out, s_cap;
  int          err_count, checks;
  // ====
  // Device and serial slave
  spimsc_top spimsc_top_inst (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_clock_pin_i(s_clk),
    .serial_clock_pin_o(sclk), .serial_clock_pin_oe_n(),
    .slave_select_lines_i(s_sel), .slave_select_lines_o(ss),
    .slave_select_lines_oe_n(ss_oe_n), .mosi_i(s_mosi), .mosi_o(mosi),
    .mosi_oe_n(), .miso_i(miso), .miso_o(s_miso), .miso_oe_n(),
    .irq(irq)
  );
  spimsc_partner spimsc_partner_inst (
    .sclk(sclk), .sel_n(ss[0]), .mosi(mosi), .tx(ptx), .miso(miso),
    .cap(cap)
  );
  always #2 mclk = ~mclk;
  // ====
  // Bus and check tasks
  task automatic apb(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= {26'h0, a};
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'h1;
    // No wait limit here; a hang is left to the watchdog
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    rd_v = prdata;
    lerr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // External master bit, six system clocks per serial period
  task automatic xbit(input logic b);
    s_mosi <= b;
    repeat (3) @(posedge mclk);
    s_clk  <= 1'h1;
    s_cap  = {s_cap[14:0], s_miso};
    repeat (3) @(posedge mclk);
    s_clk  <= 1'h0;
  endtask
  // Polls go bit, giving up after 100 reads
  task done_wait;
    int n;
    n = 0;
    do begin
      apb(1'h0, 6'h00, 32'h0);
      n++;
    end while (rd_v[0] !== 1'h0 && n < 100);
  endtask
  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) rev16[i] = v[15 - i];
  endfunction
  task end_sim;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #60000;
    err_count++;
    end_sim;
  end
  // ====
  // Tests
  initial begin
    mclk = 1'h0;
    sys_rst = 1'h1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    ptx = 32'h0;
    s_clk = 1'h0;
    s_mosi = 1'h0;
    s_sel = 2'h3;
    s_out = 16'hC35A;
    s_cap = 16'h0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'h0;
    apb(1'h0, 6'h08, 32'h0);
    chk("select_control", 32'h0, rd_v);
    apb(1'h0, 6'h10, 32'h0);
    chk("receive_word0", 32'h0, rd_v);
    apb(1'h0, 6'h34, 32'h0);
    chk("clock_pattern", 32'h007F_FF87, rd_v);
    apb(1'h0, 6'h30, 32'h0);
    chk("unmapped", 32'h1, {31'h0, lerr});
    $display("test reset values done");
    apb(1'h1, 6'h04, 32'h1);
    apb(1'h1, 6'h08, 32'h9);
    apb(1'h1, 6'h20, 32'hA5);
    ptx <= 32'h3C00_0000;
    apb(1'h1, 6'h00, 32'h0002_0045);
    done_wait;
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'h0, 6'h10, 32'h0);
    chk("rx0", 32'h3C, {24'h0, rd_v[7:0]});
    chk("sent", 32'hA5, {24'h0, cap[7:0]});
    apb(1'h1, 6'h00, 32'h0003_0004);
    @(posedge mclk);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test single word done");
    apb(1'h1, 6'h20, 32'h1234);
    apb(1'h1, 6'h24, 32'hBEEF);
    ptx <= 32'hF00F_5AC3;
    // Idle level settles first, so no stray edge under select
    apb(1'h1, 6'h00, 32'h0000_0D84);
    apb(1'h1, 6'h00, 32'h0000_0D85);
    done_wait;
    apb(1'h0, 6'h10, 32'h0);
    chk("rx0", {16'h0, rev16(16'hF00F)}, {16'h0, rd_v[15:0]});
    apb(1'h0, 6'h14, 32'h0);
    chk("rx1", {16'h0, rev16(16'h5AC3)}, {16'h0, rd_v[15:0]});
    chk("sent", {rev16(16'h1234), rev16(16'hBEEF)}, cap);
    $display("test burst done");
    apb(1'h1, 6'h08, 32'h1);
    repeat (3) @(posedge mclk);
    chk("select", 32'h2, {30'h0, ss});
    apb(1'h1, 6'h00, 32'h0000_0005);
    repeat (20) @(posedge mclk);
    apb(1'h1, 6'h00, 32'h0000_0004);
    apb(1'h0, 6'h00, 32'h0);
    chk("go_busy", 32'h0, {31'h0, rd_v[0]});
    apb(1'h0, 6'h10, 32'h0);
    chk("rx0", {16'h0, rev16(16'hF00F)}, {16'h0, rd_v[15:0]});
    apb(1'h1, 6'h08, 32'h0);
    repeat (3) @(posedge mclk);
    chk("select", 32'h3, {30'h0, ss});
    $display("test abort done");
    apb(1'h1, 6'h00, 32'h0004_0004);
    repeat (3) @(posedge mclk);
    chk("select_oe", 32'h1, {31'h0, ss_oe_n[0]});
    apb(1'h1, 6'h08, 32'h10);
    apb(1'h1, 6'h20, 32'h96);
    apb(1'h1, 6'h24, 32'h69);
    apb(1'h1, 6'h00, 32'h0004_0145);
    s_sel <= 2'h2;
    repeat (3) @(posedge mclk);
    for (int i = 15; i >= 0; i--) xbit(s_out[i]);
    repeat (3) @(posedge mclk);
    s_sel <= 2'h3;
    done_wait;
    apb(1'h0, 6'h10, 32'h0);
    chk("slave_rx0", 32'hC3, {24'h0, rd_v[7:0]});
    apb(1'h0, 6'h14, 32'h0);
    chk("slave_rx1", 32'h5A, {24'h0, rd_v[7:0]});
    chk("slave_sent", 32'h9669, {16'h0, s_cap});
    apb(1'h0, 6'h08, 32'h0);
    chk("level_done", 32'h30, {26'h0, rd_v[5:0]});
    $display("test slave mode done");
    end_sim;
  end
endmodule
